/* File: hdl/mvx_pkg.sv */
// Package for the data-move execution block: opcodes, widths and reset values
package mvx_pkg;
  localparam int PTR_W   = 16;
  localparam int DATA_W  = 8;
  localparam int BANK_W  = 5;
  localparam int PCH_W   = 7;
  localparam int FADDR_W = 7;
  localparam int OFS_W   = 6;

  localparam logic [PTR_W-1:0]   PTR_ONE   = 16'h0001;
  localparam logic [PTR_W-1:0]   PTR_RST   = 16'h0000;
  localparam logic [DATA_W-1:0]  ACC_RST   = 8'h00;
  localparam logic [BANK_W-1:0]  BANK_RST  = 5'h00;
  localparam logic [PCH_W-1:0]   PCH_RST   = 7'h00;
  localparam logic [DATA_W-1:0]  DATA_ZERO = 8'h00;

  // Operation selector presented with each instruction
  typedef enum logic [2:0] {
    MVX_OP_NONE     = 3'b000,
    MVX_OP_INDIRECT = 3'b001,
    MVX_OP_RELATIVE = 3'b010,
    MVX_OP_BANK     = 3'b011,
    MVX_OP_PCH      = 3'b100,
    MVX_OP_ACC_LIT  = 3'b101,
    MVX_OP_STORE    = 3'b110
  } mvx_op_t;

  // Pointer update mode of the indirect move
  typedef enum logic [1:0] {
    MVX_PRE_INC  = 2'b00,
    MVX_PRE_DEC  = 2'b01,
    MVX_POST_INC = 2'b10,
    MVX_POST_DEC = 2'b11
  } mvx_mode_t;

  // Read cycle sequencing of the indirect move
  typedef enum logic [0:0] {
    MVX_ST_IDLE = 1'b0,
    MVX_ST_READ = 1'b1
  } mvx_state_t;
endpackage

/* File: hdl/mvx_move_exec.sv */
// Execution logic for literal loads, accumulator store and indirect moves
// How it works
// RULE1 - Mode code picks pre/post increment or decrement
// RULE2 - Relative form: pointer plus signed offset, unchanged
// RULE3 - Pointer ends plus one, minus one, or same
// RULE4 - Indirect access goes to pointer's data address
// RULE5 - Pointer wraps modulo 16 bits
// RULE6 - Bank literal loads five bits, flags untouched
// RULE7 - PC-high literal loads seven bits, flags untouched
// RULE8 - Accumulator literal loads in one cycle, no flags
// RULE9 - Store copies accumulator to file register
// RULE10 - Indirect move sets zero flag from byte
`timescale 1ns/10ps
module mvx_move_exec (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  // Instruction issue
  input  wire logic                          OP_VALID,
  input  wire mvx_pkg::mvx_op_t              OP_CODE,
  input  wire mvx_pkg::mvx_mode_t            OP_MODE,
  input  wire logic                          OP_PTR_SEL,
  input  wire logic [7:0]                    OP_LITERAL,
  input  wire logic [mvx_pkg::OFS_W-1:0]     OP_OFFSET,
  output logic                               OP_READY,
  // Data memory port
  output logic                               MEM_RD,
  output logic                               MEM_WR,
  output logic [mvx_pkg::PTR_W-1:0]          MEM_ADDR,
  output logic [mvx_pkg::DATA_W-1:0]         MEM_WDATA,
  input  wire logic [mvx_pkg::DATA_W-1:0]    MEM_RDATA,
  // Architectural state
  output logic [mvx_pkg::DATA_W-1:0]         ACCUMULATOR,
  output logic [mvx_pkg::BANK_W-1:0]         BANK_SELECT,
  output logic [mvx_pkg::PCH_W-1:0]          PC_HIGH_LATCH,
  output logic [mvx_pkg::PTR_W-1:0]          POINTER0,
  output logic [mvx_pkg::PTR_W-1:0]          POINTER1,
  output logic                               ZERO_FLAG
);
  logic [mvx_pkg::PTR_W-1:0]  ptr_reg [2];
  logic [mvx_pkg::PTR_W-1:0]  ptr_cur;
  logic [mvx_pkg::PTR_W-1:0]  ptr_next;
  logic [mvx_pkg::PTR_W-1:0]  ptr_upd;
  logic [mvx_pkg::PTR_W-1:0]  eff_addr;
  logic [mvx_pkg::PTR_W-1:0]  ofs_ext;
  mvx_pkg::mvx_state_t        state_reg;
  logic                       issue;
  logic                       ind_op;

  assign issue   = OP_VALID && (state_reg == mvx_pkg::MVX_ST_IDLE);
  assign ind_op  = (OP_CODE == mvx_pkg::MVX_OP_INDIRECT) ||
                   (OP_CODE == mvx_pkg::MVX_OP_RELATIVE);
  assign ptr_cur = ptr_reg[OP_PTR_SEL];
  assign ofs_ext = {{(mvx_pkg::PTR_W-mvx_pkg::OFS_W){OP_OFFSET[mvx_pkg::OFS_W-1]}}, OP_OFFSET};

  // Sums are 16 bits wide so the pointer wraps on its own
  always_comb begin
    ptr_upd = mvx_pkg::MVX_PRE_INC == OP_MODE || mvx_pkg::MVX_POST_INC == OP_MODE
              ? ptr_cur + mvx_pkg::PTR_ONE : ptr_cur - mvx_pkg::PTR_ONE; // RULE5
    case (OP_MODE)
      mvx_pkg::MVX_PRE_INC,
      mvx_pkg::MVX_PRE_DEC: eff_addr = ptr_upd; // RULE1
      default:              eff_addr = ptr_cur; // RULE1
    endcase
    ptr_next = ptr_upd; // RULE3
    if (OP_CODE == mvx_pkg::MVX_OP_RELATIVE) begin
      eff_addr = ptr_cur + ofs_ext; // RULE2
      ptr_next = ptr_cur;           // RULE3
    end
  end

  // One-cycle read wait for indirect moves; all other ops finish at issue
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= mvx_pkg::MVX_ST_IDLE;
      OP_READY  <= 1'b0;
    end else begin
      case (state_reg)
        mvx_pkg::MVX_ST_IDLE: begin
          if (issue && ind_op) begin
            state_reg <= mvx_pkg::MVX_ST_READ;
            OP_READY  <= 1'b0;
          end else begin
            state_reg <= mvx_pkg::MVX_ST_IDLE;
            OP_READY  <= 1'b1;
          end
        end
        // Offers in this cycle are refused while read data lands in the accumulator
        mvx_pkg::MVX_ST_READ: begin
          state_reg <= mvx_pkg::MVX_ST_IDLE;
          OP_READY  <= 1'b1;
        end
        default: begin
          state_reg <= mvx_pkg::MVX_ST_IDLE;
          OP_READY  <= 1'b1;
        end
      endcase
    end
  end

  // Memory strobes: the indirect port itself holds nothing, the pointer addresses memory
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MEM_RD    <= 1'b0;
      MEM_WR    <= 1'b0;
      MEM_ADDR  <= mvx_pkg::PTR_RST;
      MEM_WDATA <= mvx_pkg::DATA_ZERO;
    end else begin
      MEM_RD <= issue && ind_op; // RULE4
      MEM_WR <= issue && (OP_CODE == mvx_pkg::MVX_OP_STORE); // RULE9
      if (issue && ind_op) begin
        MEM_ADDR <= eff_addr; // RULE4
      end else if (issue && OP_CODE == mvx_pkg::MVX_OP_STORE) begin
        MEM_ADDR  <= {{(mvx_pkg::PTR_W-mvx_pkg::FADDR_W){1'b0}},
                      OP_LITERAL[mvx_pkg::FADDR_W-1:0]}; // RULE9
        MEM_WDATA <= ACCUMULATOR; // RULE9
      end
    end
  end

  // One process per pointer, so the unselected pointer never moves
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ptr
      always_ff @(posedge CLK) begin
        if (RESET) begin
          ptr_reg[gi] <= mvx_pkg::PTR_RST;
        end else if (issue && ind_op && OP_PTR_SEL == 1'(gi)) begin
          ptr_reg[gi] <= ptr_next; // RULE3
        end
      end
    end
  endgenerate

  assign POINTER0 = ptr_reg[0];
  assign POINTER1 = ptr_reg[1];

  // Literal loads never touch the zero flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      BANK_SELECT   <= mvx_pkg::BANK_RST;
      PC_HIGH_LATCH <= mvx_pkg::PCH_RST;
    end else if (issue) begin
      if (OP_CODE == mvx_pkg::MVX_OP_BANK) begin
        BANK_SELECT <= OP_LITERAL[mvx_pkg::BANK_W-1:0]; // RULE6
      end
      if (OP_CODE == mvx_pkg::MVX_OP_PCH) begin
        PC_HIGH_LATCH <= OP_LITERAL[mvx_pkg::PCH_W-1:0]; // RULE7
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ACCUMULATOR <= mvx_pkg::ACC_RST;
      ZERO_FLAG   <= 1'b0;
    end else if (issue && OP_CODE == mvx_pkg::MVX_OP_ACC_LIT) begin
      ACCUMULATOR <= OP_LITERAL; // RULE8
    end else if (state_reg == mvx_pkg::MVX_ST_READ) begin
      ACCUMULATOR <= MEM_RDATA;
      ZERO_FLAG   <= (MEM_RDATA == mvx_pkg::DATA_ZERO); // RULE10
    end
  end

  a_acc_literal: assert property (@(posedge CLK) disable iff (RESET) // RULE8
    issue && OP_CODE == mvx_pkg::MVX_OP_ACC_LIT |=> ACCUMULATOR == $past(OP_LITERAL)
      && ZERO_FLAG == $past(ZERO_FLAG) && OP_READY)
    else $error("accumulator literal load wrong");
  a_bank_load: assert property (@(posedge CLK) disable iff (RESET) // RULE6
    issue && OP_CODE == mvx_pkg::MVX_OP_BANK |=> BANK_SELECT == $past(OP_LITERAL[4:0])
      && $stable(ZERO_FLAG))
    else $error("bank select load wrong");
  a_pch_load: assert property (@(posedge CLK) disable iff (RESET) // RULE7
    issue && OP_CODE == mvx_pkg::MVX_OP_PCH |=> PC_HIGH_LATCH == $past(OP_LITERAL[6:0])
      && $stable(ZERO_FLAG))
    else $error("pc high latch load wrong");
  a_store_write: assert property (@(posedge CLK) disable iff (RESET) // RULE9
    issue && OP_CODE == mvx_pkg::MVX_OP_STORE |=> MEM_WR && MEM_WDATA == ACCUMULATOR
      && MEM_ADDR == {9'h000, $past(OP_LITERAL[6:0])} && $stable(ZERO_FLAG))
    else $error("store write wrong");
  a_ind_addr: assert property (@(posedge CLK) disable iff (RESET) // RULE1
    issue && OP_CODE == mvx_pkg::MVX_OP_INDIRECT && OP_MODE == mvx_pkg::MVX_PRE_INC
      && !OP_PTR_SEL |=> MEM_RD && MEM_ADDR == $past(ptr_reg[0]) + 16'h0001)
    else $error("preincrement address wrong");
  a_ptr_post: assert property (@(posedge CLK) disable iff (RESET) // RULE3
    issue && OP_CODE == mvx_pkg::MVX_OP_INDIRECT && OP_MODE == mvx_pkg::MVX_POST_DEC
      && OP_PTR_SEL |=> POINTER1 == $past(ptr_reg[1]) - 16'h0001
      && MEM_ADDR == $past(ptr_reg[1]))
    else $error("postdecrement pointer wrong");
  a_ptr_wrap: assert property (@(posedge CLK) disable iff (RESET) // RULE5
    issue && OP_CODE == mvx_pkg::MVX_OP_INDIRECT && OP_MODE == mvx_pkg::MVX_POST_INC
      && !OP_PTR_SEL && ptr_reg[0] == 16'hFFFF |=> POINTER0 == 16'h0000)
    else $error("pointer wrap wrong");
  a_rel_hold: assert property (@(posedge CLK) disable iff (RESET) // RULE2
    issue && OP_CODE == mvx_pkg::MVX_OP_RELATIVE && !OP_PTR_SEL
      |=> $stable(POINTER0) && MEM_ADDR == POINTER0 + $past(ofs_ext))
    else $error("relative move wrong");
  a_ind_zero: assert property (@(posedge CLK) disable iff (RESET) // RULE10
    issue && ind_op |=> !OP_READY ##1 OP_READY
      && ZERO_FLAG == (ACCUMULATOR == 8'h00) && ACCUMULATOR == $past(MEM_RDATA))
    else $error("indirect move result wrong");
  a_indf_read: assert property (@(posedge CLK) disable iff (RESET) // RULE4
    MEM_RD |-> state_reg == mvx_pkg::MVX_ST_READ && !MEM_WR)
    else $error("indirect read strobe wrong");
  a_rel_ptr1: assert property (@(posedge CLK) disable iff (RESET) // RULE2
    issue && OP_CODE == mvx_pkg::MVX_OP_RELATIVE && OP_PTR_SEL
      |=> $stable(POINTER1) && MEM_ADDR == POINTER1 + $past(ofs_ext))
    else $error("relative move on pointer one wrong");
  a_ptr_other: assert property (@(posedge CLK) disable iff (RESET) // RULE3
    issue && ind_op && OP_PTR_SEL |=> $stable(POINTER0))
    else $error("unselected pointer moved");
  a_busy_refuse: assert property (@(posedge CLK) disable iff (RESET) // RULE4
    state_reg == mvx_pkg::MVX_ST_READ |-> !OP_READY ##1 !MEM_RD && !MEM_WR && OP_READY
      && $stable(BANK_SELECT) && $stable(PC_HIGH_LATCH))
    else $error("offer during read wait not refused");

  c_rel_move: cover property (@(posedge CLK) disable iff (RESET)
    issue && OP_CODE == mvx_pkg::MVX_OP_RELATIVE);
  c_wrap: cover property (@(posedge CLK) disable iff (RESET)
    issue && ind_op && ptr_cur == 16'h0000 && OP_MODE == mvx_pkg::MVX_PRE_DEC);
  c_zero_set: cover property (@(posedge CLK) disable iff (RESET) $rose(ZERO_FLAG));
  c_store: cover property (@(posedge CLK) disable iff (RESET) MEM_WR);
  c_refused: cover property (@(posedge CLK) disable iff (RESET)
    state_reg == mvx_pkg::MVX_ST_READ && OP_VALID);
endmodule // mvx_move_exec

/* File: test/test_mvx_move_exec.sv */
// Self-checking testbench for the data-move execution block
`timescale 1ns/10ps
module test_mvx_move_exec;
  logic                 CLK = 1'b0;
  logic                 RESET = 1'b1;
  logic                 OP_VALID = 1'b0;
  mvx_pkg::mvx_op_t     OP_CODE = mvx_pkg::MVX_OP_NONE;
  mvx_pkg::mvx_mode_t   OP_MODE = mvx_pkg::MVX_PRE_INC;
  logic                 OP_PTR_SEL = 1'b0;
  logic [7:0]           OP_LITERAL = 8'h00;
  logic [5:0]           OP_OFFSET = 6'h00;
  logic                 OP_READY, MEM_RD, MEM_WR, ZERO_FLAG;
  logic [15:0]          MEM_ADDR, POINTER0, POINTER1;
  logic [7:0]           MEM_WDATA, ACCUMULATOR;
  logic [7:0]           MEM_RDATA = 8'h00;
  logic [4:0]           BANK_SELECT;
  logic [6:0]           PC_HIGH_LATCH;
  int                   err_total = 0;
  int                   tests_run = 0;

  always #20 CLK = ~CLK;

  mvx_move_exec dut (.CLK(CLK), .RESET(RESET), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_MODE(OP_MODE), .OP_PTR_SEL(OP_PTR_SEL), .OP_LITERAL(OP_LITERAL),
    .OP_OFFSET(OP_OFFSET), .OP_READY(OP_READY), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR),
    .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .ACCUMULATOR(ACCUMULATOR), .BANK_SELECT(BANK_SELECT), .PC_HIGH_LATCH(PC_HIGH_LATCH),
    .POINTER0(POINTER0), .POINTER1(POINTER1), .ZERO_FLAG(ZERO_FLAG));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Offer one instruction and leave the bench just after its issue edge
  task automatic issue(input mvx_pkg::mvx_op_t c, input mvx_pkg::mvx_mode_t m, input logic s,
                       input logic [7:0] l, input logic [5:0] o, input logic [7:0] d);
    @(posedge CLK);
    OP_CODE <= c;
    OP_MODE <= m;
    OP_PTR_SEL <= s;
    OP_LITERAL <= l;
    OP_OFFSET <= o;
    MEM_RDATA <= d;
    OP_VALID <= 1'b1;
    #1 chk("ready", 16'h0001, {15'h0, OP_READY});
    @(posedge CLK);
    OP_VALID <= 1'b0;
    #1;
  endtask

  // Indirect or relative move: address and pointer at +1, accumulator and zero at +2
  task automatic ind(input mvx_pkg::mvx_op_t c, input mvx_pkg::mvx_mode_t m, input logic s,
                     input logic [5:0] o, input logic [7:0] d, input logic [15:0] ea,
                     input logic [15:0] ep);
    issue(c, m, s, 8'h00, o, d);
    chk("mem_rd", 16'h0001, {15'h0, MEM_RD});
    chk("mem_addr", ea, MEM_ADDR);
    chk("pointer", ep, s ? POINTER1 : POINTER0);
    @(posedge CLK);
    #1 chk("acc", {8'h00, d}, {8'h00, ACCUMULATOR});
    chk("zero", {15'h0, d === 8'h00}, {15'h0, ZERO_FLAG});
  endtask

  task automatic t_reset;
    chk("acc_rst", 16'h0000, {8'h00, ACCUMULATOR});
    chk("bank_rst", 16'h0000, {11'h000, BANK_SELECT});
    chk("ptr0_rst", 16'h0000, POINTER0);
    chk("ptr1_rst", 16'h0000, POINTER1);
    chk("pch_rst", 16'h0000, {9'h000, PC_HIGH_LATCH});
    chk("zero_rst", 16'h0000, {15'h0, ZERO_FLAG});
    chk("strobe_rst", 16'h0000, {14'h0, MEM_RD, MEM_WR});
    chk("ready_rst", 16'h0001, {15'h0, OP_READY});
  endtask

  // Signed offset extremes on both pointers, which must not move
  task automatic t_relative;
    ind(mvx_pkg::MVX_OP_RELATIVE, mvx_pkg::MVX_PRE_INC, 1'b0, 6'h20, 8'hA5,
        16'hFFE0, 16'h0000);
    ind(mvx_pkg::MVX_OP_RELATIVE, mvx_pkg::MVX_PRE_INC, 1'b1, 6'h1F, 8'h00,
        16'h001F, 16'h0000);
    chk("ptr0_hold", 16'h0000, POINTER0);
  endtask

  // Extra operand bits must be dropped; the zero flag left set stays set
  task automatic t_literals;
    issue(mvx_pkg::MVX_OP_BANK, mvx_pkg::MVX_PRE_INC, 1'b0, 8'hFF, 6'h00, 8'h00);
    chk("bank", 16'h001F, {11'h000, BANK_SELECT});
    issue(mvx_pkg::MVX_OP_PCH, mvx_pkg::MVX_PRE_INC, 1'b0, 8'hFF, 6'h00, 8'h00);
    chk("pch", 16'h007F, {9'h000, PC_HIGH_LATCH});
    issue(mvx_pkg::MVX_OP_ACC_LIT, mvx_pkg::MVX_PRE_INC, 1'b0, 8'h5A, 6'h00, 8'h00);
    chk("acc_lit", 16'h005A, {8'h00, ACCUMULATOR});
    chk("zero_kept", 16'h0001, {15'h0, ZERO_FLAG});
  endtask

  task automatic t_store;
    issue(mvx_pkg::MVX_OP_STORE, mvx_pkg::MVX_PRE_INC, 1'b0, 8'hFF, 6'h00, 8'h00);
    chk("mem_wr", 16'h0001, {15'h0, MEM_WR});
    chk("st_addr", 16'h007F, MEM_ADDR);
    chk("st_data", 16'h005A, {8'h00, MEM_WDATA});
    chk("st_acc", 16'h005A, {8'h00, ACCUMULATOR});
    chk("st_zero", 16'h0001, {15'h0, ZERO_FLAG});
  endtask

  // All four modes from pointer 0 at zero, crossing the wrap both ways, then pointer 1
  task automatic t_modes;
    ind(mvx_pkg::MVX_OP_INDIRECT, mvx_pkg::MVX_PRE_DEC, 1'b0, 6'h00, 8'h80,
        16'hFFFF, 16'hFFFF);
    ind(mvx_pkg::MVX_OP_INDIRECT, mvx_pkg::MVX_PRE_INC, 1'b0, 6'h00, 8'h00,
        16'h0000, 16'h0000);
    ind(mvx_pkg::MVX_OP_INDIRECT, mvx_pkg::MVX_POST_DEC, 1'b0, 6'h00, 8'h01,
        16'h0000, 16'hFFFF);
    ind(mvx_pkg::MVX_OP_INDIRECT, mvx_pkg::MVX_POST_INC, 1'b0, 6'h00, 8'hFF,
        16'hFFFF, 16'h0000);
    ind(mvx_pkg::MVX_OP_INDIRECT, mvx_pkg::MVX_POST_DEC, 1'b1, 6'h00, 8'h7E,
        16'h0000, 16'hFFFF);
  endtask

  // A literal offered in the read wait is held, refused there and taken one cycle later
  task automatic t_busy;
    @(posedge CLK);
    OP_CODE <= mvx_pkg::MVX_OP_INDIRECT;
    OP_MODE <= mvx_pkg::MVX_POST_INC;
    OP_PTR_SEL <= 1'b1;
    MEM_RDATA <= 8'h3C;
    OP_VALID <= 1'b1;
    @(posedge CLK);
    OP_CODE <= mvx_pkg::MVX_OP_ACC_LIT;
    OP_LITERAL <= 8'hC3;
    #1 chk("busy_ready", 16'h0000, {15'h0, OP_READY});
    @(posedge CLK);
    #1 chk("busy_acc", 16'h003C, {8'h00, ACCUMULATOR});
    chk("busy_rd", 16'h0000, {15'h0, MEM_RD});
    chk("busy_ptr", 16'h0000, POINTER1);
    @(posedge CLK);
    OP_VALID <= 1'b0;
    #1 chk("late_acc", 16'h00C3, {8'h00, ACCUMULATOR});
  endtask

  initial begin
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    #1 t_reset;
    t_relative;
    t_literals;
    t_store;
    t_modes;
    t_busy;
    print_verdict;
  end

  // The sequence needs well under 100 cycles; a hang is cut off long after that
  initial begin
    repeat (2000) @(posedge CLK);
    err_total++;
    print_verdict;
  end
endmodule // test_mvx_move_exec
